// *** common/pwmts_pkg.sv ***
// package: register map, field layout, reset values and timing counts of the pwm timing block
package pwmts_pkg;

    // ==================================================================
    // bus and structure
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int N_TIMERS = 3;
    localparam int N_CHANS  = 4;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] ROUTE_OFF     = 12'h000;
    localparam logic [ADDR_W-1:0] TPER_BASE     = 12'h010;
    localparam logic [ADDR_W-1:0] TCTL_BASE     = 12'h020;
    localparam logic [ADDR_W-1:0] TMR_STRIDE    = 12'h004;
    localparam logic [ADDR_W-1:0] CH_BASE       = 12'h040;
    localparam logic [ADDR_W-1:0] CH_STRIDE     = 12'h010;
    localparam logic [ADDR_W-1:0] CH_DUTY_OFF   = 12'h000;
    localparam logic [ADDR_W-1:0] CH_CTRL_OFF   = 12'h004;
    localparam logic [ADDR_W-1:0] CH_DBAND_OFF  = 12'h008;
    localparam logic [ADDR_W-1:0] CH_ACTIVE_OFF = 12'h00C;

    // ==================================================================
    // field positions
    localparam int TCTL_EN_BIT    = 0;
    localparam int TCTL_PS_LO     = 1;
    localparam int TCTL_CNT_LO    = 8;
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_DLSB_LO   = 4;
    localparam int CTRL_MODE_LO   = 6;
    localparam int SEL_W          = 2;

    // ==================================================================
    // reset values
    localparam logic [7:0] ROUTE_RST = 8'h00;
    localparam logic [7:0] TPER_RST  = 8'hFF;
    localparam logic [7:0] TCTL_RST  = 8'h00;
    localparam logic [7:0] CH_RST    = 8'h00;

    // ==================================================================
    // timing: timer ticks once per four oscillator periods at prescale 1, one clock each
    localparam int OSC_PER_TICK  = 4;
    localparam int DLY_UNIT_CYC  = OSC_PER_TICK;
    localparam int DLY_W         = 9;

    // ==================================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timer routing codes
    typedef enum logic [1:0] {
        PWMTS_SEL_T2  = 2'b00,
        PWMTS_SEL_T4  = 2'b01,
        PWMTS_SEL_T6  = 2'b10,
        PWMTS_SEL_RSV = 2'b11
    } pwmts_sel_t;

    // output steering modes
    typedef enum logic [1:0] {
        PWMTS_MODE_SINGLE = 2'b00,
        PWMTS_MODE_FWD    = 2'b01,
        PWMTS_MODE_HALF   = 2'b10,
        PWMTS_MODE_REV    = 2'b11
    } pwmts_mode_t;

endpackage

// *** common/pwmts_tb_if.sv ***
// interface: time base of one timer as seen by the channels
interface pwmts_tb_if;
    logic [7:0] count;
    logic [1:0] fine;
    logic       wrap;
    modport src (output count, output fine, output wrap);
    modport snk (input count, input fine, input wrap);
endinterface

// *** logic/pwmts_timer.sv ***
// module: one 8-bit period timer with prescaler and 10-bit time base
module pwmts_timer
    import pwmts_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       en,
    input  wire logic [1:0] presc,
    input  wire logic [7:0] period,
    pwmts_tb_if.src         tb
);
    logic [7:0] sub_q;
    logic [7:0] sub_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] limit;
    logic [7:0] shifted;
    logic       tick_end;

    // ==================================================================
    // prescale 1/4/16/64 times four oscillator periods per timer tick
    always_comb begin
        limit    = 8'((OSC_PER_TICK << (2 * presc)) - 1);
        tick_end = (sub_q == limit);
        shifted  = sub_q >> (2 * presc);
        sub_d    = sub_q;
        cnt_d    = cnt_q;
        if (en) begin
            if (tick_end) begin
                sub_d = 8'h00;
                cnt_d = (cnt_q == period) ? 8'h00 : 8'(cnt_q + 8'h01);
            end else begin
                sub_d = 8'(sub_q + 8'h01);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_q <= 8'h00;
            cnt_q <= 8'h00;
        end else if (ce) begin
            sub_q <= sub_d;
            cnt_q <= cnt_d;
        end
    end

    assign tb.count = cnt_q;
    assign tb.fine  = shifted[1:0];
    assign tb.wrap  = en && tick_end && (cnt_q == period);

endmodule // pwmts_timer

// *** logic/pwmts_top.sv ***
// module: pwm timing block with timer routing, duty double buffer and dead band
//
// The register offsets and register access over AXI4-Lite were decided locally.
module pwmts_top
    import pwmts_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [DATA_W-1:0] S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [DATA_W-1:0]      S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    output logic [N_CHANS-1:0]     OUTPUT_A,
    output logic [N_CHANS-1:0]     OUTPUT_B,
    output logic [N_CHANS-1:0]     OUTPUT_C,
    output logic [N_CHANS-1:0]     OUTPUT_D
);
    // ==================================================================
    // register state
    logic [7:0]       pwm_timer_routing_select_q;
    logic [7:0]       pwm_timer_routing_select_d;
    logic [7:0]       period_limit_reg_q    [N_TIMERS];
    logic [7:0]       period_limit_reg_d    [N_TIMERS];
    logic [7:0]       timer_ctrl_q          [N_TIMERS];
    logic [7:0]       timer_ctrl_d          [N_TIMERS];
    logic [7:0]       duty_high_bits_reg_q  [N_CHANS];
    logic [7:0]       duty_high_bits_reg_d  [N_CHANS];
    logic [7:0]       channel_control_reg_q [N_CHANS];
    logic [7:0]       channel_control_reg_d [N_CHANS];
    logic [7:0]       dead_band_delay_reg_q [N_CHANS];
    logic [7:0]       dead_band_delay_reg_d [N_CHANS];

    // channel state
    logic [9:0]       active_duty_latch_q   [N_CHANS];
    logic [9:0]       active_duty_latch_d   [N_CHANS];
    logic             raw_q                 [N_CHANS];
    logic             raw_d                 [N_CHANS];
    logic [DLY_W-1:0] dly_q                 [N_CHANS];
    logic [DLY_W-1:0] dly_d                 [N_CHANS];
    logic [3:0]       outs_q                [N_CHANS];
    logic [3:0]       outs_d                [N_CHANS];

    // bus state
    logic              bvalid_q;
    logic              bvalid_d;
    logic [1:0]        bresp_q;
    logic [1:0]        bresp_d;
    logic              rvalid_q;
    logic              rvalid_d;
    logic [1:0]        rresp_q;
    logic [1:0]        rresp_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              wr_go;
    logic              rd_go;

    // time bases
    logic [7:0]        t_count [N_TIMERS];
    logic [1:0]        t_fine  [N_TIMERS];
    logic              t_wrap  [N_TIMERS];

    // ==================================================================
    // three timers
    pwmts_tb_if tbus [N_TIMERS] ();

    for (genvar g = 0; g < N_TIMERS; g++) begin : g_tmr
        pwmts_timer u_timer (
            .clk    (CLK),
            .rst_n  (RST_N),
            .ce     (CE),
            .en     (timer_ctrl_q[g][TCTL_EN_BIT]),
            .presc  (timer_ctrl_q[g][TCTL_PS_LO +: 2]),
            .period (period_limit_reg_q[g]),
            .tb     (tbus[g])
        );
        assign t_count[g] = tbus[g].count;
        assign t_fine[g]  = tbus[g].fine;
        assign t_wrap[g]  = tbus[g].wrap;
    end

    // ==================================================================
    // axi4-lite handshakes: write address and data taken together
    assign wr_go         = CE && S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q;
    assign rd_go         = CE && S_AXI_ARVALID && !rvalid_q;
    assign S_AXI_AWREADY = wr_go;
    assign S_AXI_WREADY  = wr_go;
    assign S_AXI_ARREADY = rd_go;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RRESP   = rresp_q;
    assign S_AXI_RDATA   = rdata_q;

    // ==================================================================
    // register writes
    always_comb begin
        logic hit;
        hit = 1'b0;
        pwm_timer_routing_select_d = pwm_timer_routing_select_q;
        period_limit_reg_d         = period_limit_reg_q;
        timer_ctrl_d               = timer_ctrl_q;
        duty_high_bits_reg_d       = duty_high_bits_reg_q;
        channel_control_reg_d      = channel_control_reg_q;
        dead_band_delay_reg_d      = dead_band_delay_reg_q;
        bvalid_d = (bvalid_q && !S_AXI_BREADY) || wr_go;
        bresp_d  = bresp_q;
        if (wr_go) begin
            if (S_AXI_AWADDR == ROUTE_OFF) begin
                hit = 1'b1;
                if (S_AXI_WSTRB[0]) begin
                    pwm_timer_routing_select_d = S_AXI_WDATA[7:0];
                end
            end
            for (int t = 0; t < N_TIMERS; t++) begin
                if (S_AXI_AWADDR == 12'(TPER_BASE + t * TMR_STRIDE)) begin
                    hit = 1'b1;
                    if (S_AXI_WSTRB[0]) period_limit_reg_d[t] = S_AXI_WDATA[7:0];
                end else if (S_AXI_AWADDR == 12'(TCTL_BASE + t * TMR_STRIDE)) begin
                    hit = 1'b1;
                    if (S_AXI_WSTRB[0]) timer_ctrl_d[t] = S_AXI_WDATA[7:0];
                end
            end
            for (int c = 0; c < N_CHANS; c++) begin
                if (S_AXI_AWADDR == 12'(CH_BASE + c * CH_STRIDE + CH_DUTY_OFF)) begin
                    hit = 1'b1;
                    if (S_AXI_WSTRB[0]) duty_high_bits_reg_d[c] = S_AXI_WDATA[7:0];
                end else if (S_AXI_AWADDR == 12'(CH_BASE + c * CH_STRIDE + CH_CTRL_OFF)) begin
                    hit = 1'b1;
                    if (S_AXI_WSTRB[0]) channel_control_reg_d[c] = S_AXI_WDATA[7:0];
                end else if (S_AXI_AWADDR == 12'(CH_BASE + c * CH_STRIDE + CH_DBAND_OFF)) begin
                    hit = 1'b1;
                    if (S_AXI_WSTRB[0]) dead_band_delay_reg_d[c] = {1'b0, S_AXI_WDATA[6:0]};
                end else if (S_AXI_AWADDR == 12'(CH_BASE + c * CH_STRIDE + CH_ACTIVE_OFF)) begin
                    hit = 1'b1;
                end
            end
            bresp_d = hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ==================================================================
    // register reads
    always_comb begin
        logic hit;
        hit      = 1'b0;
        rvalid_d = (rvalid_q && !S_AXI_RREADY) || rd_go;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (rd_go) begin
            rdata_d = '0;
            if (S_AXI_ARADDR == ROUTE_OFF) begin
                hit     = 1'b1;
                rdata_d = {24'h00_0000, pwm_timer_routing_select_q};
            end
            for (int t = 0; t < N_TIMERS; t++) begin
                if (S_AXI_ARADDR == 12'(TPER_BASE + t * TMR_STRIDE)) begin
                    hit     = 1'b1;
                    rdata_d = {24'h00_0000, period_limit_reg_q[t]};
                end else if (S_AXI_ARADDR == 12'(TCTL_BASE + t * TMR_STRIDE)) begin
                    hit     = 1'b1;
                    rdata_d = {16'h0000, t_count[t], timer_ctrl_q[t]};
                end
            end
            for (int c = 0; c < N_CHANS; c++) begin
                if (S_AXI_ARADDR == 12'(CH_BASE + c * CH_STRIDE + CH_DUTY_OFF)) begin
                    hit     = 1'b1;
                    rdata_d = {24'h00_0000, duty_high_bits_reg_q[c]};
                end else if (S_AXI_ARADDR == 12'(CH_BASE + c * CH_STRIDE + CH_CTRL_OFF)) begin
                    hit     = 1'b1;
                    rdata_d = {24'h00_0000, channel_control_reg_q[c]};
                end else if (S_AXI_ARADDR == 12'(CH_BASE + c * CH_STRIDE + CH_DBAND_OFF)) begin
                    hit     = 1'b1;
                    rdata_d = {24'h00_0000, dead_band_delay_reg_q[c]};
                end else if (S_AXI_ARADDR == 12'(CH_BASE + c * CH_STRIDE + CH_ACTIVE_OFF)) begin
                    hit     = 1'b1;
                    rdata_d = {16'h0000, outs_q[c], raw_q[c], 1'b0, active_duty_latch_q[c]};
                end
            end
            rresp_d = hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ==================================================================
    // channel waveform generation
    always_comb begin
        pwmts_sel_t       sel;
        pwmts_mode_t      mode;
        logic [7:0]       cnt;
        logic [1:0]       fine;
        logic             wrap;
        logic             live;
        logic [9:0]       duty;
        logic [DLY_W-1:0] dly_len;
        logic             settled;
        logic             mod_hi;
        logic             mod_lo;
        sel = PWMTS_SEL_T2;
        mode = PWMTS_MODE_SINGLE;
        cnt = 8'h00;
        fine = 2'b00;
        wrap = 1'b0;
        live = 1'b0;
        duty = 10'h000;
        dly_len = '0;
        settled = 1'b0;
        mod_hi = 1'b0;
        mod_lo = 1'b0;
        for (int c = 0; c < N_CHANS; c++) begin
            sel  = pwmts_sel_t'(pwm_timer_routing_select_q[SEL_W*c +: SEL_W]);
            mode = pwmts_mode_t'(channel_control_reg_q[c][CTRL_MODE_LO +: 2]);
            live = channel_control_reg_q[c][CTRL_EN_BIT];
            duty = {duty_high_bits_reg_q[c], channel_control_reg_q[c][CTRL_DLSB_LO +: 2]};
            case (sel)
                PWMTS_SEL_T2: begin
                    cnt = t_count[0]; fine = t_fine[0]; wrap = t_wrap[0];
                end
                PWMTS_SEL_T4: begin
                    cnt = t_count[1]; fine = t_fine[1]; wrap = t_wrap[1];
                end
                PWMTS_SEL_T6: begin
                    cnt = t_count[2]; fine = t_fine[2]; wrap = t_wrap[2];
                end
                default: begin
                    cnt = 8'h00; fine = 2'b00; wrap = 1'b0; live = 1'b0;
                end
            endcase
            active_duty_latch_d[c] = active_duty_latch_q[c];
            raw_d[c] = raw_q[c];
            if (!live) begin
                raw_d[c] = 1'b0;
            end else if (wrap) begin
                active_duty_latch_d[c] = duty;
                raw_d[c] = (duty != 10'h000);
            end else if ({cnt, fine} == active_duty_latch_q[c]) begin
                raw_d[c] = 1'b0;
            end
            // dead band: count restarts on every edge of the raw wave
            dly_len = DLY_W'(dead_band_delay_reg_q[c][6:0] * DLY_UNIT_CYC);
            if (raw_d[c] != raw_q[c]) begin
                dly_d[c] = '0;
            end else if (dly_q[c] < dly_len) begin
                dly_d[c] = DLY_W'(dly_q[c] + 1'b1);
            end else begin
                dly_d[c] = dly_q[c];
            end
            settled = (raw_d[c] == raw_q[c]) && (dly_q[c] >= dly_len);
            mod_hi  = raw_q[c] && settled;
            mod_lo  = !raw_q[c] && settled;
            case (mode)
                PWMTS_MODE_SINGLE: outs_d[c] = {3'b000, mod_hi};
                PWMTS_MODE_HALF:   outs_d[c] = {2'b00, mod_lo, mod_hi};
                PWMTS_MODE_FWD:    outs_d[c] = {mod_hi, 2'b00, 1'b1};
                default:           outs_d[c] = {1'b0, 1'b1, mod_hi, 1'b0};
            endcase
            if (!live) outs_d[c] = 4'h0;
        end
    end

    // ==================================================================
    // state registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pwm_timer_routing_select_q <= ROUTE_RST;
            for (int t = 0; t < N_TIMERS; t++) begin
                period_limit_reg_q[t] <= TPER_RST;
                timer_ctrl_q[t]       <= TCTL_RST;
            end
            for (int c = 0; c < N_CHANS; c++) begin
                duty_high_bits_reg_q[c]  <= CH_RST;
                channel_control_reg_q[c] <= CH_RST;
                dead_band_delay_reg_q[c] <= CH_RST;
                active_duty_latch_q[c]   <= 10'h000;
                raw_q[c]                 <= 1'b0;
                dly_q[c]                 <= '0;
                outs_q[c]                <= 4'h0;
            end
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
        end else if (CE) begin
            pwm_timer_routing_select_q <= pwm_timer_routing_select_d;
            period_limit_reg_q         <= period_limit_reg_d;
            timer_ctrl_q               <= timer_ctrl_d;
            duty_high_bits_reg_q       <= duty_high_bits_reg_d;
            channel_control_reg_q      <= channel_control_reg_d;
            dead_band_delay_reg_q      <= dead_band_delay_reg_d;
            active_duty_latch_q        <= active_duty_latch_d;
            raw_q                      <= raw_d;
            dly_q                      <= dly_d;
            outs_q                     <= outs_d;
            bvalid_q                   <= bvalid_d;
            bresp_q                    <= bresp_d;
            rvalid_q                   <= rvalid_d;
            rresp_q                    <= rresp_d;
            rdata_q                    <= rdata_d;
        end
    end

    for (genvar c = 0; c < N_CHANS; c++) begin : g_out
        assign OUTPUT_A[c] = outs_q[c][0];
        assign OUTPUT_B[c] = outs_q[c][1];
        assign OUTPUT_C[c] = outs_q[c][2];
        assign OUTPUT_D[c] = outs_q[c][3];
    end

endmodule // pwmts_top

// *** dv/pwmts_asserts.sv ***
// checker: bus handshakes of the pwm timing block, with a cover on OUTPUT_A[0] pulses
module pwmts_asserts
    import pwmts_pkg::*;
(
    input wire logic              CLK,
    input wire logic              RST_N,
    input wire logic              CE,
    input wire logic              S_AXI_AWVALID,
    input wire logic              S_AXI_AWREADY,
    input wire logic              S_AXI_WVALID,
    input wire logic              S_AXI_WREADY,
    input wire logic [1:0]        S_AXI_BRESP,
    input wire logic              S_AXI_BVALID,
    input wire logic              S_AXI_BREADY,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic [DATA_W-1:0] S_AXI_RDATA,
    input wire logic              S_AXI_RVALID,
    input wire logic              S_AXI_RREADY,
    input wire logic [N_CHANS-1:0] OUTPUT_A
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // ==================================================================
    // bus handshakes
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> S_AXI_BVALID)
        else $error("write not answered one cycle after taking");
    a_bvalid_cause: assert property ($rose(S_AXI_BVALID) |-> $past(S_AXI_AWREADY && S_AXI_WVALID))
        else $error("write answer without a taken write");
    a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped before bready");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered one cycle after taking");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped before rready");
    a_ready_pair: assert property (S_AXI_AWREADY == (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && CE))
        else $error("write readies not taken together");
    a_read_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while answer pending");
    a_ce_freeze: assert property (!CE |-> !S_AXI_AWREADY && !S_AXI_ARREADY && !S_AXI_WREADY)
        else $error("ready high while clock enable low");
    c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
    c_pulse: cover property ($rose(OUTPUT_A[0]));
endmodule // pwmts_asserts

bind pwmts_top pwmts_asserts u_pwmts_asserts (.CLK, .RST_N, .CE, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .OUTPUT_A);

// *** dv/pwmts_load.sv ***
// partner: load on one output pin, measuring period and high time in clocks
module pwmts_load (
    input wire logic       clk,
    input wire logic [3:0] pin,
    input wire logic [1:0] pick,
    output int             high_len,
    output int             per_len,
    output int             rises
);
    timeunit 1ns;
    timeprecision 1ps;
    int   hcnt = 0;
    int   pcnt = 0;
    logic last = 1'b0;
    initial {high_len, per_len, rises} = '0;
    // ==================================================================
    // edge timing of the picked pin
    always @(posedge clk) begin
        last <= pin[pick];
        pcnt <= (pin[pick] && !last) ? 1 : pcnt + 1;
        hcnt <= pin[pick] ? (last ? hcnt + 1 : 1) : 0;
        if (pin[pick] && !last) begin
            per_len <= pcnt;
            rises   <= rises + 1;
        end
        if (!pin[pick] && last) begin
            high_len <= hcnt;
        end
    end
endmodule // pwmts_load

// *** dv/pwmts_top_bench.sv ***
// testbench: register bus, timer routing, period, duty and dead band checks
module pwmts_top_bench;
    import pwmts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RST_N = 1'b0, CE = 1'b1;
    logic [ADDR_W-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic [DATA_W-1:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'h1;
    logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
    logic S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, pick = 2'h0;
    logic [N_CHANS-1:0] OUTPUT_A, OUTPUT_B, OUTPUT_C, OUTPUT_D;
    int err_total = 0, tests_run = 0, cyc = 0, high_len, per_len, rises;
    logic [DATA_W-1:0] rd;
    int per[3] = '{16, 24, 32};
    int hi[3] = '{6, 6, 24};
    initial forever #2.5 CLK = ~CLK;
    pwmts_top u_pwmts_top (.CLK, .RST_N, .CE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
        .S_AXI_RVALID, .S_AXI_RREADY, .OUTPUT_A, .OUTPUT_B, .OUTPUT_C, .OUTPUT_D);
    pwmts_load u_pwmts_load (.clk(CLK), .pin(OUTPUT_A), .pick, .high_len, .per_len, .rises);
    // ==================================================================
    // bus and compare tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        S_AXI_AWADDR <= a; S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1; S_AXI_WVALID <= 1'b1; S_AXI_BREADY <= 1'b1;
        do @(posedge CLK); while (!(S_AXI_AWREADY && S_AXI_WREADY));
        S_AXI_AWVALID <= 1'b0; S_AXI_WVALID <= 1'b0;
        do @(posedge CLK); while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
        check(32'(S_AXI_BRESP), 32'(er));
        @(posedge CLK);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] m,
                       input logic [1:0] er = RESP_OKAY);
        S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1'b1; S_AXI_RREADY <= 1'b1;
        do @(posedge CLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'b0;
        do @(posedge CLK); while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
        check(S_AXI_RDATA & m, ex);
        check(32'(S_AXI_RRESP), 32'(er));
        @(posedge CLK);
    endtask
    function automatic logic [11:0] cha(input int c, input logic [11:0] off);
        return 12'(CH_BASE + CH_STRIDE * c + off);
    endfunction
    task automatic meas(input int ep, input int eh);
        int r;
        r = rises;
        while (rises < r + 3) @(posedge CLK);
        check(per_len, ep);
        check(high_len, eh);
    endtask
    task automatic idle();
        int r;
        repeat (40) @(posedge CLK);
        r = rises;
        repeat (80) @(posedge CLK);
        check(rises, r);
        check(32'(OUTPUT_A[pick]), 32'h0000_0000);
    endtask
    task automatic scan(input logic [3:0] on, input logic [3:0] mo);
        int n;
        logic [3:0] o;
        n = 0;
        repeat (40) @(posedge CLK);
        repeat (48) begin
            @(posedge CLK);
            o = {OUTPUT_D[0], OUTPUT_C[0], OUTPUT_B[0], OUTPUT_A[0]};
            n += int'((o & mo) != 4'h0);
            check(32'(o & ~mo), 32'(on));
        end
        check(n, 12);
    endtask
    // ==================================================================
    // scenarios
    task automatic t_reset();
        rdc(ROUTE_OFF, 32'h0000_0000, 32'h0000_00FF);
        rdc(TPER_BASE, 32'h0000_00FF, 32'h0000_00FF);
        CE <= 1'b0;
        repeat (3) @(posedge CLK);
        CE <= 1'b1;
        wr(12'h100, 32'h0000_0055, RESP_SLVERR);
        rdc(12'h100, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
        $display("test reset done");
    endtask
    task automatic t_route();
        for (int t = 0; t < 3; t++) begin
            wr(12'(TPER_BASE + TMR_STRIDE * t), 32'(t == 0 ? 3 : t == 1 ? 5 : 1));
            wr(12'(TCTL_BASE + TMR_STRIDE * t), t == 2 ? 32'h0000_0003 : 32'h0000_0001);
        end
        for (int c = 0; c < 4; c++) begin
            wr(cha(c, CH_DUTY_OFF), 32'h0000_0001);
            wr(cha(c, CH_CTRL_OFF), 32'h0000_0021);
            pick <= 2'(c);
            for (int k = 0; k < 3; k++) begin
                wr(ROUTE_OFF, 32'(k << (2 * c)));
                meas(per[k], hi[k]);
            end
            wr(ROUTE_OFF, 32'(3 << (2 * c)));
            idle();
        end
        $display("test route done");
    endtask
    task automatic t_duty();
        pick <= 2'h0;
        wr(ROUTE_OFF, 32'h0000_0000);
        wr(cha(0, CH_DUTY_OFF), 32'h0000_0000);
        wr(cha(0, CH_CTRL_OFF), 32'h0000_0001);
        idle();
        wr(cha(0, CH_DUTY_OFF), 32'h0000_0003);
        meas(16, 12);
        rdc(cha(0, CH_ACTIVE_OFF), 32'h0000_000C, 32'h0000_03FF);
        wr(cha(0, CH_DBAND_OFF), 32'h0000_0002);
        meas(16, 4);
        wr(cha(0, CH_CTRL_OFF), 32'h0000_0041);
        scan(4'h1, 4'h8);
        wr(cha(0, CH_CTRL_OFF), 32'h0000_00C1);
        scan(4'h4, 4'h2);
        $display("test duty done");
    endtask
    // ==================================================================
    // run control
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        t_reset();
        t_route();
        t_duty();
        report_and_stop();
    end
endmodule // pwmts_top_bench
